// ### core/lsrc_top.sv
// Purpose: Line status readout and ring detector control behind APB.
// Assumes: Pin inputs are asynchronous and pass two flip-flops first.
// Notes:   One sample frame is FRAME_CYC clock cycles.
// What this block does and what its controller must do
// R1: Force on-hook leaves the off-hook counter untouched, not restarted.
// R2: Fast DC termination drives off-hook with fast settling enabled.
// R3: Controller should not send data during fast DC termination.
// R4: Controller clears monitor select before setting hook control.
// R5: Controller sets hook control and monitor select in separate writes.
// R6: Full-wave select 0 gives half-wave, 1 gives full-wave ring rectify.
// R7: Rectification applies to ring detect pin and serial ring data.
// R8: Controller pulses ring squelch at least 1 ms after reversal or ring.
// R9: Controller avoids ring squelch while alternate caller-ID squelch is on.
// R10: Sense field shows voltage or current chosen by mode, hook, monitor.
// R11: On-hook voltage code: 2.75 V steps, 0 no line, 31 maximum.
// R12: Off-hook current code: 3 mA steps, 0 low, 1..30 normal, 31 overload.
// R13: Current overload above 140 mA, or above 54 mA in CTR21 mode.
// R14: Live overload flag follows the overload and clears by itself.
// R15: Live overload masked only by off-hook counter, not billing tone.
// R16: Dropout flag sets when the line supply collapses while off-hook.
// R17: Dropout flag clears sixteen frames after the supply returns.
// R18: Dropout flag reads zero whenever on-hook.
// R19: Overload protect flag is 1 while protection is active.
// R20: Status register is read-only and reads zero after reset.
`timescale 1ns/1ps
`default_nettype none
module lsrc_top
    import lsrc_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic             PREADY,
    output logic      [31:0] PRDATA,
    output logic             PSLVERR,
    input  wire logic [9:0]  LINE_VOLT_Q,
    input  wire logic [9:0]  LOOP_MA,
    input  wire logic        LINE_SUPPLY_OK,
    input  wire logic        RX_OVERLOAD,
    input  wire logic        OVERLOAD_TRIP,
    input  wire logic        RING_INPUT_A,
    input  wire logic        RING_INPUT_B,
    input  wire logic        LINE_DATA,
    output logic             OFFHOOK_DRIVE,
    output logic             DC_TERM_FAST,
    output logic             RING_DETECT_OUT,
    output logic             SERIAL_DATA_OUT
);
    // Frame divider.
    logic [10:0] fcnt_reg, fcnt_next;
    logic        frame_reg, frame_next;

    // Two-flop synchronisers for all pin inputs.
    logic [9:0]  volt_s1_reg, volt_reg;
    logic [9:0]  amp_s1_reg, amp_reg;
    logic [5:0]  pins_s1_reg, pins_reg;
    logic        sup_ok, rx_ovl, ovl_trip, ring_a, ring_b, line_bit;

    // Software registers.
    logic [7:0]  hook_reg, hook_next;
    logic [7:0]  cfg_reg, cfg_next;
    logic [7:0]  ring_reg, ring_next;
    logic        rov_reg, rov_next;

    // Hook state and off-hook counter.
    lsrc_hook_e  hs;
    logic        offhook;
    logic [7:0]  ohcnt_reg, ohcnt_next;
    logic        ohmask;

    // Dropout detection.
    logic        dod_reg, dod_next;
    logic [4:0]  dcnt_reg, dcnt_next;

    // Overload flags and sense codes.
    logic        ovl_reg, ovl_next;
    logic        opd_reg, opd_next;
    logic [4:0]  vcode, icode;
    logic [4:0]  sense_reg, sense_next;
    logic        i_over;

    // Ring path outputs.
    logic        ring_raw;
    logic        ring_detect_out_reg, ring_detect_out_next;
    logic        sdo_reg, sdo_next;

    // Bus decode.
    logic        setup, wr_en, hit;
    logic [7:0]  rd_byte;
    logic [31:0] prdata_reg, prdata_next;

    // Divide the core clock down to one pulse per sample frame.
    always_comb begin
        frame_next = 1'b0;
        fcnt_next  = fcnt_reg + 11'h001;
        if (fcnt_reg == FRAME_CNT_MAX) begin
            fcnt_next  = 11'h000;
            frame_next = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            fcnt_reg  <= 11'h000;
            frame_reg <= 1'b0;
        end else begin
            fcnt_reg  <= fcnt_next;
            frame_reg <= frame_next;
        end
    end

    // Synchronise every pin; only the second stage is read by logic.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            volt_s1_reg <= 10'h000;
            volt_reg    <= 10'h000;
            amp_s1_reg  <= 10'h000;
            amp_reg     <= 10'h000;
            pins_s1_reg <= 6'h00;
            pins_reg    <= 6'h00;
        end else begin
            volt_s1_reg <= LINE_VOLT_Q;
            volt_reg    <= volt_s1_reg;
            amp_s1_reg  <= LOOP_MA;
            amp_reg     <= amp_s1_reg;
            pins_s1_reg <= {LINE_DATA, RING_INPUT_B, RING_INPUT_A,
                            OVERLOAD_TRIP, RX_OVERLOAD, LINE_SUPPLY_OK};
            pins_reg    <= pins_s1_reg;
        end
    end

    assign {line_bit, ring_b, ring_a, ovl_trip, rx_ovl, sup_ok} = pins_reg;

    // APB decode; the status index takes no write.
    assign setup = PSEL && !PENABLE;
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign hit   = (PADDR == ADDR_HOOK) || (PADDR == ADDR_CFG) ||
                   (PADDR == ADDR_RING) || (PADDR == ADDR_STATUS);

    // Software-written control bits and the sticky overload flag.
    always_comb begin
        hook_next = hook_reg;
        cfg_next  = cfg_reg;
        ring_next = ring_reg;
        rov_next  = rov_reg;
        if (wr_en && PADDR == ADDR_HOOK) begin
            hook_next = {5'h00, PWDATA[2:0]};
        end
        if (wr_en && PADDR == ADDR_CFG) begin
            cfg_next = {5'h00, PWDATA[2:0]};
            if (!PWDATA[ROV_BIT]) begin
                rov_next = 1'b0;
            end
        end
        if (wr_en && PADDR == ADDR_RING) begin
            ring_next = {5'h00, PWDATA[2:0]};
        end
        // A new overload wins over a clear in the same cycle.
        if (rx_ovl && !ohmask && !cfg_reg[BTE_BIT]) begin
            rov_next = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            hook_reg <= HOOK_RST;
            cfg_reg  <= CFG_RST;
            ring_reg <= RING_RST;
            rov_reg  <= 1'b0;
        end else begin
            hook_reg <= hook_next;
            cfg_reg  <= cfg_next;
            ring_reg <= ring_next;
            rov_reg  <= rov_next;
        end
    end

    // Decode the hook state from mode, hook and monitor bits.
    always_comb begin
        case ({hook_reg[MODE_BIT], hook_reg[HOOK_BIT], hook_reg[ONHOOK_MONITOR_SEL_BIT]})
            3'b010: hs = HS_OFFHOOK;
            3'b011: hs = HS_FAST_DCT;
            3'b001: hs = HS_ONHOOK_MON;
            3'b101: hs = HS_ONHOOK_MON;
            3'b110: hs = HS_FORCE_ON;
            3'b111: hs = HS_FORCE_MON;
            default: hs = HS_ONHOOK;
        endcase
    end

    assign offhook       = (hs == HS_OFFHOOK) || (hs == HS_FAST_DCT);
    assign OFFHOOK_DRIVE = offhook;
    assign DC_TERM_FAST  = (hs == HS_FAST_DCT); // see R2

    // Off-hook counter masks overload early in a call.
    always_comb begin
        ohcnt_next = ohcnt_reg;
        if (hs == HS_ONHOOK || hs == HS_ONHOOK_MON) begin
            ohcnt_next = 8'h00;
        end else if (offhook && frame_reg && ohcnt_reg != OFFHOOK_MASK_FR) begin
            ohcnt_next = ohcnt_reg + 8'h01;
        end
        // Force on-hook states fall through and hold the count. see R1
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ohcnt_reg <= 8'h00;
        end else begin
            ohcnt_reg <= ohcnt_next;
        end
    end

    assign ohmask = !offhook || (ohcnt_reg != OFFHOOK_MASK_FR);

    // Dropout flag: set on supply loss off-hook, clear after 16 frames.
    always_comb begin
        dod_next  = dod_reg;
        dcnt_next = dcnt_reg;
        if (!offhook) begin
            dod_next  = 1'b0; // see R18
            dcnt_next = 5'h00;
        end else if (!sup_ok) begin
            dod_next  = 1'b1; // see R16
            dcnt_next = 5'h00;
        end else if (dod_reg && frame_reg) begin
            if (dcnt_reg == DROPOUT_FRAMES - 5'h01) begin
                dod_next  = 1'b0; // see R17
                dcnt_next = 5'h00;
            end else begin
                dcnt_next = dcnt_reg + 5'h01;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            dod_reg  <= 1'b0;
            dcnt_reg <= 5'h00;
        end else begin
            dod_reg  <= dod_next;
            dcnt_reg <= dcnt_next;
        end
    end

    // Quantise line voltage and loop current once per frame.
    lsrc_quant u_volt (
        .clk     (CLK),
        .reset_n (RESET_N),
        .start   (frame_reg),
        .value   (volt_reg),
        .offset  (V_MIN_Q),
        .step    (V_STEP_Q),
        .cap     (CODE_MAX),
        .code    (vcode)
    );

    lsrc_quant u_amp (
        .clk     (CLK),
        .reset_n (RESET_N),
        .start   (frame_reg),
        .value   (amp_reg),
        .offset  (I_MIN_MA),
        .step    (I_STEP_MA),
        .cap     (CODE_NORMMAX),
        .code    (icode)
    );

    // Overload threshold depends on the CTR21 termination mode.
    assign i_over = cfg_reg[CTR21_BIT] ? (amp_reg > I_OVL_C21_MA)
                                       : (amp_reg > I_OVL_MA); // see R13

    // Sense field, live overload and protect flags.
    always_comb begin
        sense_next = sense_reg;
        if (frame_reg) begin
            if (offhook) begin
                sense_next = i_over ? CODE_MAX : icode; // see R10, R12
            end else begin
                sense_next = vcode; // see R10, R11
            end
        end
        ovl_next = rx_ovl && !ohmask; // see R14, R15
        opd_next = ovl_trip && cfg_reg[OPE_BIT]; // see R19
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sense_reg <= 5'h00;
            ovl_reg   <= 1'b0;
            opd_reg   <= 1'b0;
        end else begin
            sense_reg <= sense_next;
            ovl_reg   <= ovl_next;
            opd_reg   <= opd_next;
        end
    end

    // Ring rectification feeds both the pin and the serial stream.
    always_comb begin
        if (ring_reg[RING_FULL_WAVE_SEL_BIT]) begin
            ring_raw = ring_a || ring_b; // see R6
        end else begin
            ring_raw = ring_a;
        end
        ring_detect_out_next = ring_raw && !ring_reg[RING_SQUELCH_BIT] && !offhook;
        sdo_next  = sdo_reg;
        if (frame_reg) begin
            case (hs)
                HS_ONHOOK:   sdo_next = ring_detect_out_next; // see R7
                HS_FORCE_ON: sdo_next = 1'b0;
                default:     sdo_next = line_bit;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ring_detect_out_reg <= 1'b0;
            sdo_reg  <= 1'b0;
        end else begin
            ring_detect_out_reg <= ring_detect_out_next;
            sdo_reg  <= sdo_next;
        end
    end

    assign RING_DETECT_OUT = ring_detect_out_reg; // see R7
    assign SERIAL_DATA_OUT = sdo_reg;

    // Read mux; status is the sense code and the overload, dropout and protect flags. see R20
    always_comb begin
        case (PADDR)
            ADDR_HOOK:   rd_byte = hook_reg;
            ADDR_CFG:    rd_byte = {rov_reg, cfg_reg[6:0]};
            ADDR_RING:   rd_byte = ring_reg;
            ADDR_STATUS: rd_byte = {sense_reg, ovl_reg, dod_reg, opd_reg};
            default:     rd_byte = 8'h00;
        endcase
        prdata_next = prdata_reg;
        if (setup && !PWRITE) begin
            prdata_next = {24'h000000, rd_byte};
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            prdata_reg <= 32'h00000000;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    // Zero-wait slave; unmapped addresses answer with an error.
    assign PREADY  = 1'b1;
    assign PRDATA  = prdata_reg;
    assign PSLVERR = PSEL && PENABLE && !hit;
endmodule
`default_nettype wire

// ### include/lsrc_pkg.sv
// Purpose: Shared constants and types for the line status and ring control.
// Assumes: 10 MHz core clock, 8 kHz sample frames on the isolation link.
// Notes:   Register byte address is four times the register index.
package lsrc_pkg;

    // Clock and frame timing.
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          FS_HZ         = 8_000;
    localparam int          FRAME_CYC     = CLK_HZ / FS_HZ;
    localparam logic [10:0] FRAME_CNT_MAX = 11'(FRAME_CYC - 1);
    localparam logic [4:0]  DROPOUT_FRAMES  = 5'h10;
    localparam logic [7:0]  OFFHOOK_MASK_FR = 8'h80;

    // Register indices and byte addresses.
    localparam logic [7:0]  IDX_HOOK   = 8'h10;
    localparam logic [7:0]  IDX_CFG    = 8'h11;
    localparam logic [7:0]  IDX_RING   = 8'h12;
    localparam logic [7:0]  IDX_STATUS = 8'h13;
    localparam logic [11:0] ADDR_HOOK   = {2'h0, IDX_HOOK, 2'h0};
    localparam logic [11:0] ADDR_CFG    = {2'h0, IDX_CFG, 2'h0};
    localparam logic [11:0] ADDR_RING   = {2'h0, IDX_RING, 2'h0};
    localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};

    // Field positions.
    localparam int HOOK_BIT  = 0;
    localparam int ONHOOK_MONITOR_SEL_BIT  = 1;
    localparam int MODE_BIT  = 2;
    localparam int CTR21_BIT = 0;
    localparam int BTE_BIT   = 1;
    localparam int OPE_BIT   = 2;
    localparam int ROV_BIT   = 7;
    localparam int RING_SQUELCH_BIT  = 0;
    localparam int RING_FULL_WAVE_SEL_BIT  = 1;
    localparam int CID_SQUELCH_ALT_BIT  = 2;
    localparam int SENSE_LSB = 3;
    localparam int OVL_BIT   = 2;
    localparam int DOD_BIT   = 1;
    localparam int OPD_BIT   = 0;

    // Reset values.
    localparam logic [7:0] HOOK_RST   = 8'h00;
    localparam logic [7:0] CFG_RST    = 8'h00;
    localparam logic [7:0] RING_RST   = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;

    // Sense scaling: voltage in quarter volts, current in mA.
    localparam logic [9:0] V_MIN_Q      = 10'h00c;
    localparam logic [9:0] V_STEP_Q     = 10'h00b;
    localparam logic [9:0] I_MIN_MA     = 10'h003;
    localparam logic [9:0] I_STEP_MA    = 10'h003;
    localparam logic [9:0] I_OVL_MA     = 10'h08c;
    localparam logic [9:0] I_OVL_C21_MA = 10'h036;
    localparam logic [4:0] CODE_MAX     = 5'h1f;
    localparam logic [4:0] CODE_NORMMAX = 5'h1e;

    // Hook states decoded from the mode, hook and monitor bits.
    typedef enum logic [2:0] {
        HS_ONHOOK,
        HS_ONHOOK_MON,
        HS_OFFHOOK,
        HS_FAST_DCT,
        HS_FORCE_ON,
        HS_FORCE_MON
    } lsrc_hook_e;

endpackage

// ### core/lsrc_quant.sv
// Purpose: Turns a sensed value into a 5-bit code by repeated subtraction.
// Assumes: Start comes no more often than every 40 cycles.
// Notes:   Code is 0 below offset, else 1 plus whole steps, capped.
`timescale 1ns/1ps
`default_nettype none
module lsrc_quant
    import lsrc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       start,
    input  wire logic [9:0] value,
    input  wire logic [9:0] offset,
    input  wire logic [9:0] step,
    input  wire logic [4:0] cap,
    output logic      [4:0] code
);
    logic [9:0] rem_reg;
    logic [9:0] rem_next;
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    logic       busy_reg;
    logic       busy_next;
    logic [4:0] code_reg;
    logic [4:0] code_next;

    // Step the remainder down one step per cycle until it or the cap runs out.
    always_comb begin
        rem_next  = rem_reg;
        cnt_next  = cnt_reg;
        busy_next = busy_reg;
        code_next = code_reg;
        if (start) begin
            if (value < offset) begin
                code_next = 5'h00;
                busy_next = 1'b0;
            end else begin
                rem_next  = value - offset;
                cnt_next  = 5'h01;
                busy_next = 1'b1;
            end
        end else if (busy_reg) begin
            if (rem_reg >= step && cnt_reg < cap) begin
                rem_next = rem_reg - step;
                cnt_next = cnt_reg + 5'h01;
            end else begin
                code_next = cnt_reg;
                busy_next = 1'b0;
            end
        end
    end

    // Conversion state.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rem_reg  <= 10'h000;
            cnt_reg  <= 5'h00;
            busy_reg <= 1'b0;
            code_reg <= 5'h00;
        end else begin
            rem_reg  <= rem_next;
            cnt_reg  <= cnt_next;
            busy_reg <= busy_next;
            code_reg <= code_next;
        end
    end

    assign code = code_reg;
endmodule
`default_nettype wire

// ### verif/lsrc_props.sv
// Purpose: Concurrent checks on the status and ring control ports.
// Assumes: One clock domain; reset is asynchronous, active low.
// Notes:   Counters give slack for the two-flop input synchronisers.
`timescale 1ns/1ps
`default_nettype none
module lsrc_props
    import lsrc_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RESET_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        RX_OVERLOAD,
    input wire logic        OVERLOAD_TRIP,
    input wire logic        OFFHOOK_DRIVE,
    input wire logic        DC_TERM_FAST,
    input wire logic        RING_DETECT_OUT
);
    logic        rd_st;
    logic        wr_any;
    logic [3:0]  onh_reg, onh_next, trip_reg, trip_next, ovl_reg, ovl_next;
    logic [17:0] cum_reg, cum_next;

    // Counts up to fifteen and then holds.
    function automatic logic [3:0] sat(input logic [3:0] c);
        return (c == 4'hf) ? c : c + 4'h1;
    endfunction

    // Access phases of a status read and of any write.
    assign rd_st  = PSEL && PENABLE && !PWRITE && PADDR == ADDR_STATUS;
    assign wr_any = PSEL && PENABLE && PWRITE;

    // Quiet-time counters and a total of off-hook cycles since reset.
    always_comb begin
        onh_next  = OFFHOOK_DRIVE ? 4'h0 : sat(onh_reg);
        trip_next = OVERLOAD_TRIP ? 4'h0 : sat(trip_reg);
        ovl_next  = RX_OVERLOAD ? 4'h0 : sat(ovl_reg);
        cum_next  = cum_reg + 18'(OFFHOOK_DRIVE && !(&cum_reg));
    end

    // Registers the counters; reset clears them.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            onh_reg  <= 4'h0;
            trip_reg <= 4'h0;
            ovl_reg  <= 4'h0;
            cum_reg  <= 18'h0;
        end else begin
            onh_reg  <= onh_next;
            trip_reg <= trip_next;
            ovl_reg  <= ovl_next;
            cum_reg  <= cum_next;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    property p_fast; DC_TERM_FAST |-> OFFHOOK_DRIVE; endproperty
    a_fast: assert property (p_fast)
        else $error("fast termination while not off-hook");
    property p_hold;
        !wr_any |=> $stable(OFFHOOK_DRIVE) && $stable(DC_TERM_FAST);
    endproperty
    a_hold: assert property (p_hold)
        else $error("hook state moved without a write");
    property p_gate; OFFHOOK_DRIVE [*3] |-> !RING_DETECT_OUT; endproperty
    a_gate: assert property (p_gate)
        else $error("ring detect high while off-hook");
    property p_dod; rd_st && onh_reg > 4'h3 |-> !PRDATA[DOD_BIT]; endproperty
    a_dod: assert property (p_dod)
        else $error("dropout flag set while on-hook");
    property p_opd; rd_st && trip_reg > 4'h7 |-> !PRDATA[OPD_BIT]; endproperty
    a_opd: assert property (p_opd)
        else $error("protect flag set with trip low");
    property p_ovl; rd_st && ovl_reg > 4'h7 |-> !PRDATA[OVL_BIT]; endproperty
    a_ovl: assert property (p_ovl)
        else $error("live overload did not clear");
    property p_mask;
        rd_st && cum_reg < 18'h249f0 |-> !PRDATA[OVL_BIT];
    endproperty
    a_mask: assert property (p_mask)
        else $error("live overload before off-hook count");
    property p_rst;
        disable iff (1'b0)
        !RESET_N |-> PRDATA == 32'h0 && !OFFHOOK_DRIVE && !RING_DETECT_OUT;
    endproperty
    a_rst: assert property (p_rst)
        else $error("outputs not clear in reset");

    c_read: cover property (rd_st);
    c_ring: cover property ($rose(RING_DETECT_OUT));
    c_dct:  cover property (DC_TERM_FAST);
endmodule
`default_nettype wire

// ### verif/lsrc_ctrl_model.sv
// Purpose: Controller model that reaches the registers over APB.
// Assumes: The slave answers when PREADY is high at a rising edge.
// Notes:   Keeps the ordering the controller owes the device.
`timescale 1ns/1ps
`default_nettype none
module lsrc_ctrl_model
    import lsrc_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        PREADY,
    input  wire logic [31:0] PRDATA,
    input  wire logic        PSLVERR,
    output logic             PSEL,
    output logic             PENABLE,
    output logic             PWRITE,
    output logic      [11:0] PADDR,
    output logic      [31:0] PWDATA
);
    // Squelch hold a little over 1 ms at the 10 MHz clock.
    localparam int SQL_HOLD_CYC = 10_050;
    logic [7:0]  hook_now = 8'h00;
    logic        last_err = 1'b0;
    logic [31:0] junk;

    // Bus idles until the first transfer.
    initial begin
        PSEL    = 1'b0;
        PENABLE = 1'b0;
        PWRITE  = 1'b0;
        PADDR   = 12'h000;
        PWDATA  = 32'h0;
    end

    // One transfer; only register traffic, never line data.
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        @(posedge CLK);
        PSEL   <= 1'b1;
        PWRITE <= w;
        PADDR  <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        r        = PRDATA;
        last_err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    // Writes a register and tracks the hook register.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, {24'h0, d}, junk);
        if (a == ADDR_HOOK) hook_now = d;
    endtask

    // Monitor select is cleared first, hook set in its own write.
    task automatic set_hook(input logic [7:0] v);
        if (v[HOOK_BIT]) begin
            wr(ADDR_HOOK, hook_now & 8'hfd);
            wr(ADDR_HOOK, v & 8'hfd);
        end
        wr(ADDR_HOOK, v);
    endtask

    // Squelch pulse after a ring; caller-ID squelch stays off.
    task automatic squelch(input logic full);
        wr(ADDR_RING, {6'h0, full, 1'b1});
        repeat (SQL_HOLD_CYC) @(posedge CLK);
        wr(ADDR_RING, {6'h0, full, 1'b0});
    endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Purpose: Self-checking bench for the line status and ring control.
// Assumes: Controller model drives APB; the bench drives line pins.
// Notes:   Sense rows wait two frames; dropout waits real frames.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import lsrc_pkg::*;
;
    typedef struct packed {
        logic [2:0] hook;
        logic       c21;
        logic [9:0] volt;
        logic [9:0] cur;
        logic [4:0] code;
    } lsrc_row_s;
    logic        CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, q;
    logic [9:0]  LINE_VOLT_Q, LOOP_MA;
    logic        LINE_SUPPLY_OK, RX_OVERLOAD, OVERLOAD_TRIP, LINE_DATA;
    logic        RING_INPUT_A, RING_INPUT_B, OFFHOOK_DRIVE, DC_TERM_FAST;
    logic        RING_DETECT_OUT, SERIAL_DATA_OUT;
    int          fails = 0;
    int          check_count = 0;
    // Rows: hook register, CTR21, quarter volts, mA, expected code.
    lsrc_row_s rows [13] = '{
        '{3'h0, 1'b0, 10'h00b, 10'h000, 5'h00},
        '{3'h0, 1'b0, 10'h00c, 10'h000, 5'h01},
        '{3'h6, 1'b0, 10'h043, 10'h000, 5'h06},
        '{3'h4, 1'b0, 10'h156, 10'h000, 5'h1f},
        '{3'h5, 1'b0, 10'h022, 10'h000, 5'h03},
        '{3'h1, 1'b0, 10'h000, 10'h002, 5'h00},
        '{3'h1, 1'b0, 10'h000, 10'h003, 5'h01},
        '{3'h1, 1'b0, 10'h000, 10'h05c, 5'h1e},
        '{3'h1, 1'b0, 10'h000, 10'h08c, 5'h1e},
        '{3'h1, 1'b0, 10'h000, 10'h08d, 5'h1f},
        '{3'h1, 1'b1, 10'h000, 10'h036, 5'h12},
        '{3'h1, 1'b1, 10'h000, 10'h037, 5'h1f},
        '{3'h3, 1'b0, 10'h000, 10'h01e, 5'h0a}
    };

    lsrc_top        DUT (.*);
    lsrc_ctrl_model u_ctrl (.*);

    // Compares and counts; a mismatch is reported at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
    endtask

    task automatic st();
        u_ctrl.xfer(1'b0, ADDR_STATUS, 32'h0, q);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Clock of 100 ns period.
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    // Watchdog: the run needs about 68000 cycles.
    initial begin
        cyc(95000);
        fails++;
        final_report();
    end

    // Reset, the sense table, then the awkward cases.
    initial begin
        RESET_N        = 1'b0;
        LINE_VOLT_Q    = 10'h000;
        LOOP_MA        = 10'h000;
        LINE_SUPPLY_OK = 1'b1;
        RX_OVERLOAD    = 1'b0;
        OVERLOAD_TRIP  = 1'b0;
        RING_INPUT_A   = 1'b0;
        RING_INPUT_B   = 1'b0;
        LINE_DATA      = 1'b0;
        cyc(12);
        RESET_N <= 1'b1;
        u_ctrl.wr(ADDR_STATUS, 8'hff);
        st();
        check(q, {24'h0, STATUS_RST});
        u_ctrl.xfer(1'b0, 12'h050, 32'h0, q);
        check(q, 32'h0);
        check(32'(u_ctrl.last_err), 32'h1);
        foreach (rows[k]) begin
            LINE_VOLT_Q <= rows[k].volt;
            LOOP_MA     <= rows[k].cur;
            u_ctrl.wr(ADDR_CFG, {7'h0, rows[k].c21});
            u_ctrl.set_hook({5'h0, rows[k].hook});
            cyc(2600);
            st();
            check(32'(q[7:3]), 32'(rows[k].code));
            check(32'(OFFHOOK_DRIVE), 32'(rows[k].hook inside {3'h1, 3'h3}));
            check(32'(DC_TERM_FAST), 32'(rows[k].hook == 3'h3));
        end
        u_ctrl.wr(ADDR_CFG, 8'h04);
        OVERLOAD_TRIP <= 1'b1;
        cyc(10);
        st();
        check(32'(q[OPD_BIT]), 32'h1);
        OVERLOAD_TRIP <= 1'b0;
        u_ctrl.set_hook(8'h01);
        u_ctrl.wr(ADDR_CFG, 8'h02);
        RX_OVERLOAD <= 1'b1;
        cyc(10);
        st();
        check(32'(q[OVL_BIT]), 32'h0);
        RX_OVERLOAD    <= 1'b0;
        LINE_SUPPLY_OK <= 1'b0;
        cyc(10);
        st();
        check(32'(q[DOD_BIT]), 32'h1);
        LINE_SUPPLY_OK <= 1'b1;
        cyc(17500);
        st();
        check(32'(q[DOD_BIT]), 32'h1);
        cyc(3800);
        st();
        check(32'(q[DOD_BIT]), 32'h0);
        LINE_SUPPLY_OK <= 1'b0;
        u_ctrl.set_hook(8'h00);
        cyc(10);
        st();
        check(32'(q[DOD_BIT]), 32'h0);
        LINE_SUPPLY_OK <= 1'b1;
        RING_INPUT_B   <= 1'b1;
        cyc(10);
        check(32'(RING_DETECT_OUT), 32'h0);
        u_ctrl.wr(ADDR_RING, 8'h02);
        cyc(1300);
        check(32'(RING_DETECT_OUT), 32'h1);
        check(32'(SERIAL_DATA_OUT), 32'h1);
        u_ctrl.wr(ADDR_RING, 8'h00);
        cyc(1300);
        check(32'(SERIAL_DATA_OUT), 32'h0);
        fork
            u_ctrl.squelch(1'b1);
            begin
                cyc(30);
                check(32'(RING_DETECT_OUT), 32'h0);
            end
        join
        cyc(10);
        check(32'(RING_DETECT_OUT), 32'h1);
        final_report();
    end
endmodule

bind lsrc_top lsrc_props u_props (.*);
`default_nettype wire
